// ===== hdl/tsw_pkg.sv
// Trip status word logic: constants, codes and register map.
// Assumes a single 200 MHz controller clock and a 32-bit register port.
package tsw_pkg;

    // ------------------------------------------------------------
    // Clock and qualification timing
    // ------------------------------------------------------------
    localparam int unsigned TSW_CLK_HZ = 200_000_000;
    localparam int unsigned TSW_TICK_MS = 1;
    localparam int unsigned TSW_TICK_CYC = TSW_CLK_HZ / 1000 * TSW_TICK_MS;

    // Qualification delays in ms
    localparam logic [15:0] TSW_DLY_OVERSPEED_MS = 16'h0064;
    localparam logic [15:0] TSW_DLY_MISSING_PULSE_MS = 16'hea60;
    localparam logic [15:0] TSW_DLY_FIELD_OVERCURRENT_MS = 16'h3a98;
    localparam logic [15:0] TSW_DLY_HEATSINK_MS = 16'h02ee;
    localparam logic [15:0] TSW_DLY_NONE_MS = 16'h0000;

    // ------------------------------------------------------------
    // Trip bit positions
    // ------------------------------------------------------------
    localparam int TSW_B_OVERSPEED = 0;
    localparam int TSW_B_MISSING_PULSE = 1;
    localparam int TSW_B_FIELD_OVERCURRENT = 2;
    localparam int TSW_B_HEATSINK = 3;
    localparam int TSW_B_THERMISTOR = 4;
    localparam int TSW_B_ARMATURE_OVERVOLTAGE = 5;
    localparam int TSW_B_SPEED_FEEDBACK_FAULT = 6;
    localparam int TSW_B_ENCODER = 7;
    localparam int TSW_B_FIELD_FAILED = 8;
    localparam int TSW_B_PHASE_LOSS = 9;
    localparam int TSW_B_PHASE_LOCK = 10;
    localparam int TSW_B_LINK_RECEIVE_ERROR = 11;
    localparam int TSW_B_STALL = 12;
    localparam int TSW_B_OVERCURRENT = 13;
    localparam int TSW_B_OTHER = 14;
    localparam int TSW_B_CURRENT_TRANSFORMER_FAULT = 15;
    localparam int TSW_NUM_TRIPS = 16;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [15:0] TSW_CODE_NO_ALARM = 16'h0000;
    localparam logic [15:0] TSW_CODE_AUTOTUNE_ERROR = 16'hf001;
    localparam logic [15:0] TSW_CODE_AUTOTUNE_ABORTED = 16'hf002;
    localparam logic [15:0] TSW_CODE_EXTERNAL_TRIP = 16'hf005;
    localparam logic [15:0] TSW_CODE_REMOTE_TRIP = 16'hf006;
    localparam logic [15:0] TSW_CODE_CONFIG_ENABLED = 16'hf200;
    localparam logic [15:0] TSW_CODE_NO_OP_STATION = 16'hf400;
    localparam logic [15:0] TSW_CODE_PCB_VERSION = 16'hff05;
    localparam logic [15:0] TSW_CODE_PRODUCT_CODE = 16'hff06;
    localparam logic [3:0] TSW_EXT_CLASS = 4'hf;

    typedef enum logic [2:0] {
        TSW_OTH_AUTOTUNE_ERROR = 3'h0,
        TSW_OTH_AUTOTUNE_ABORTED = 3'h1,
        TSW_OTH_EXTERNAL_TRIP = 3'h2,
        TSW_OTH_REMOTE_TRIP = 3'h3,
        TSW_OTH_CONFIG_ENABLED = 3'h4,
        TSW_OTH_NO_OP_STATION = 3'h5,
        TSW_OTH_PCB_VERSION = 3'h6,
        TSW_OTH_PRODUCT_CODE = 3'h7
    } tsw_other_cause_t;

    // ------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------
    localparam int TSW_AW = 8;
    localparam int TSW_DW = 32;
    localparam logic [7:0] TSW_A_LATEST = 8'h00;
    localparam logic [7:0] TSW_A_WORD = 8'h04;
    localparam logic [7:0] TSW_A_FIRST = 8'h08;
    localparam logic [7:0] TSW_A_LATEST_TEXT = 8'h0c;
    localparam logic [7:0] TSW_A_WORD_TEXT = 8'h10;
    localparam logic [7:0] TSW_A_FIRST_TEXT = 8'h14;
    localparam logic [7:0] TSW_A_ENABLE = 8'h18;
    localparam logic [15:0] TSW_RST_WORD = 16'h0000;
    localparam logic [15:0] TSW_RST_FIRST = 16'h0000;
    localparam logic [15:0] TSW_RST_ENABLE = 16'hffff;

    // Digit rendering
    localparam logic [7:0] TSW_ASCII_ZERO = 8'h30;
    localparam logic [7:0] TSW_ASCII_ALPHA = 8'h37;
    localparam logic [3:0] TSW_DIGIT_TEN = 4'ha;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tsw_bus_req_t;

    function automatic logic [15:0] tsw_dly_ms(input int idx);
        case (idx)
            TSW_B_OVERSPEED: tsw_dly_ms = TSW_DLY_OVERSPEED_MS;
            TSW_B_MISSING_PULSE: tsw_dly_ms = TSW_DLY_MISSING_PULSE_MS;
            TSW_B_FIELD_OVERCURRENT: tsw_dly_ms = TSW_DLY_FIELD_OVERCURRENT_MS;
            TSW_B_HEATSINK: tsw_dly_ms = TSW_DLY_HEATSINK_MS;
            default: tsw_dly_ms = TSW_DLY_NONE_MS;
        endcase
    endfunction

    function automatic logic [15:0] tsw_ext_code(input tsw_other_cause_t sel);
        case (sel)
            TSW_OTH_AUTOTUNE_ERROR: tsw_ext_code = TSW_CODE_AUTOTUNE_ERROR;
            TSW_OTH_AUTOTUNE_ABORTED: tsw_ext_code = TSW_CODE_AUTOTUNE_ABORTED;
            TSW_OTH_EXTERNAL_TRIP: tsw_ext_code = TSW_CODE_EXTERNAL_TRIP;
            TSW_OTH_REMOTE_TRIP: tsw_ext_code = TSW_CODE_REMOTE_TRIP;
            TSW_OTH_CONFIG_ENABLED: tsw_ext_code = TSW_CODE_CONFIG_ENABLED;
            TSW_OTH_NO_OP_STATION: tsw_ext_code = TSW_CODE_NO_OP_STATION;
            TSW_OTH_PCB_VERSION: tsw_ext_code = TSW_CODE_PCB_VERSION;
            default: tsw_ext_code = TSW_CODE_PRODUCT_CODE;
        endcase
    endfunction

    function automatic logic [7:0] tsw_hex_char(input logic [3:0] d);
        if (d < TSW_DIGIT_TEN) begin
            tsw_hex_char = TSW_ASCII_ZERO + {4'h0, d};
        end else begin
            tsw_hex_char = TSW_ASCII_ALPHA + {4'h0, d};
        end
    endfunction

    function automatic logic [31:0] tsw_hex_text(input logic [15:0] v);
        tsw_hex_text = {tsw_hex_char(v[15:12]), tsw_hex_char(v[11:8]),
                        tsw_hex_char(v[7:4]), tsw_hex_char(v[3:0])};
    endfunction

endpackage

// ===== hdl/tsw_trip_status.sv
// Trip status word logic: alarm qualification, live word, first-trip
// capture, latest-alarm record and register read port.
// Assumes fault inputs and start input synchronous to i_mclk.
//
// Summary of operation
// - Every new trip, except one starting in the same cycle as an other-class trip, leaves its code in the alarm record for later reading.
// - The live word follows the set of active alarms, one bit per alarm, one clock after each alarm qualifies.
// - The live word clears to 0x0000 when start is raised while no trip is present.
// - The first-trip capture takes the code of the first trip and then ignores later ones.
// - The first-trip capture clears to 0x0000 whenever start is raised.
// - The latest-alarm record holds the newest alarm code and the down key clears it.
// - After power-up the latest-alarm record shows the no-active-alarms code.
// - All three values are 16-bit codes, one unique code per trip.
// - Several simultaneous trips report the OR of their single-bit codes, except in the latest-alarm record when the other class is among them.
// - Value 01A8 means field failed, encoder, armature overvoltage and heatsink together.
// - In the latest-alarm record the other class becomes an extended cause code.
// - Rendered digits 10 to 15 appear as letters A to F.
// - Four alarms (overspeed, missing pulse, field overcurrent, heatsink) set their bit only after persisting for their qualification delay.

// ----------------------------------------------------------------
// Persistence qualifier for one alarm
// ----------------------------------------------------------------
module tsw_qual_delay
    import tsw_pkg::*;
#(
    parameter logic [15:0] P_DLY_MS = 16'h0000
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_raw,
    input wire logic i_tick,
    output logic o_qual
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic qual_d;
    wire logic done = (cnt_q >= P_DLY_MS);

    // Any drop of the condition restarts the delay
    assign cnt_d = (!i_raw) ? 16'h0000 : ((i_tick && !done) ? cnt_q + 16'h0001 : cnt_q);
    assign qual_d = i_raw && done;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= 16'h0000;
            o_qual <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            o_qual <= qual_d;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    a_qual_needs_raw: assert property (o_qual |-> $past(i_raw) && $past(done))
        else $error("alarm qualified without persisting condition");
    a_qual_drops: assert property (!i_raw |=> !o_qual)
        else $error("alarm stayed qualified after condition dropped");
endmodule

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module tsw_trip_status
    import tsw_pkg::*;
#(
    parameter int unsigned P_TICK_CYC = TSW_TICK_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [15:0] i_alarm_raw,
    input wire tsw_other_cause_t i_other_cause,
    input wire logic i_run_start_input,
    input wire logic i_down_key,
    input wire tsw_bus_req_t i_bus,
    output logic [31:0] o_rdata,
    output logic [15:0] o_trip_status_word,
    output logic [15:0] o_first_trip_capture,
    output logic [15:0] o_latest_alarm_code,
    output logic o_tripped
);

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_q;
    logic [31:0] tick_cnt_d;
    wire logic tick_end = (tick_cnt_q == 32'(P_TICK_CYC - 1));

    assign tick_cnt_d = tick_end ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Alarm qualification
    // ------------------------------------------------------------
    logic [15:0] enable_q;
    logic [15:0] active;
    wire logic [15:0] raw_en = i_alarm_raw & enable_q;

    // One qualifier per bit, positions fixed by the bit constants
    genvar gi;
    generate
        for (gi = 0; gi < TSW_NUM_TRIPS; gi++) begin : g_qual
            tsw_qual_delay #(
                .P_DLY_MS(tsw_dly_ms(gi))
            ) u_qual (
                .i_mclk(i_mclk),
                .i_rst_b(i_rst_b),
                .i_raw(raw_en[gi]),
                .i_tick(tick_end),
                .o_qual(active[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Status values
    // ------------------------------------------------------------
    logic [15:0] word_q;
    logic [15:0] word_d;
    logic [15:0] first_q;
    logic [15:0] first_d;
    logic [15:0] latest_q;
    logic [15:0] latest_d;
    logic [15:0] act_prev_q;

    wire logic any_active = (active != 16'h0000);
    wire logic [15:0] new_bits = active & ~act_prev_q;
    wire logic any_new = (new_bits != 16'h0000);
    wire logic start_clear = i_run_start_input && !any_active;

    // Live set is the OR of active bits; held after the trip until start
    assign word_d = any_active ? active : (start_clear ? TSW_RST_WORD : word_q);

    // Start wins; otherwise only an empty capture takes a trip
    assign first_d = i_run_start_input ? TSW_RST_FIRST
                   : ((first_q == TSW_RST_FIRST) ? active : first_q);

    // A new trip wins over a clear in the same cycle
    assign latest_d = any_new ? (new_bits[TSW_B_OTHER] ? tsw_ext_code(i_other_cause) : new_bits)
                    : (i_down_key ? TSW_CODE_NO_ALARM : latest_q);

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            word_q <= TSW_RST_WORD;
            first_q <= TSW_RST_FIRST;
            latest_q <= TSW_CODE_NO_ALARM;
            act_prev_q <= 16'h0000;
        end else begin
            word_q <= word_d;
            first_q <= first_d;
            latest_q <= latest_d;
            act_prev_q <= active;
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    logic [31:0] rdata_d;
    logic [15:0] enable_d;
    logic tripped_q;

    wire logic wr_enable = i_bus.wr && (i_bus.addr == TSW_A_ENABLE);

    assign enable_d = wr_enable ? i_bus.wdata[15:0] : enable_q;

    // Text reads render each digit, letters for 10 to 15
    assign rdata_d = !i_bus.rd ? 32'h0000_0000
        : (i_bus.addr == TSW_A_LATEST) ? {16'h0000, latest_q}
        : (i_bus.addr == TSW_A_WORD) ? {16'h0000, word_q}
        : (i_bus.addr == TSW_A_FIRST) ? {16'h0000, first_q}
        : (i_bus.addr == TSW_A_LATEST_TEXT) ? tsw_hex_text(latest_q)
        : (i_bus.addr == TSW_A_WORD_TEXT) ? tsw_hex_text(word_q)
        : (i_bus.addr == TSW_A_FIRST_TEXT) ? tsw_hex_text(first_q)
        : (i_bus.addr == TSW_A_ENABLE) ? {16'h0000, enable_q}
        : 32'h0000_0000;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enable_q <= TSW_RST_ENABLE;
            o_rdata <= 32'h0000_0000;
            tripped_q <= 1'b0;
        end else begin
            enable_q <= enable_d;
            o_rdata <= rdata_d;
            tripped_q <= any_active;
        end
    end

    assign o_trip_status_word = word_q;
    assign o_first_trip_capture = first_q;
    assign o_latest_alarm_code = latest_q;
    assign o_tripped = tripped_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    a_word_tracks_set: assert property (any_active |=> word_q == $past(active))
        else $error("live word does not follow active alarms");
    a_word_start_clear: assert property (start_clear |=> word_q == 16'h0000)
        else $error("live word not cleared by start");
    a_word_holds_idle: assert property (!any_active && !i_run_start_input |=> $stable(word_q))
        else $error("live word changed with no alarm and no start");
    a_first_start_clear: assert property (i_run_start_input |=> first_q == 16'h0000)
        else $error("first trip capture not cleared by start");
    a_first_ignores_later: assert property (
        first_q != 16'h0000 && !i_run_start_input |=> $stable(first_q))
        else $error("first trip capture overwritten by a later alarm");
    a_first_takes_trip: assert property (
        first_q == 16'h0000 && !i_run_start_input && any_active
        |=> first_q == $past(active))
        else $error("first trip capture missed the first trip");
    a_latest_new_code: assert property (
        any_new && !new_bits[TSW_B_OTHER] |=> latest_q == $past(new_bits))
        else $error("latest alarm record missed a new trip");
    a_latest_ext_class: assert property (
        new_bits[TSW_B_OTHER] |=> latest_q == tsw_ext_code($past(i_other_cause)))
        else $error("other class not replaced by extended code");
    a_latest_down_clear: assert property (i_down_key && !any_new |=> latest_q == 16'h0000)
        else $error("down key did not clear latest alarm record");
    a_read_one_cycle: assert property (!i_bus.rd |=> o_rdata == 32'h0000_0000)
        else $error("read data present without a read");
    a_text_letter: assert property (
        i_bus.rd && i_bus.addr == TSW_A_WORD_TEXT && word_q[7:4] == 4'ha
        |=> o_rdata[15:8] == 8'h41)
        else $error("digit ten not rendered as a letter");

endmodule

// ===== tb/tsw_fault_src.sv
// Model of the drive fault detectors feeding the trip status logic.
// Assumes the bench sets condition levels just after a rising edge.

// ------------------------------------------------------------
// Fault detector model
// ------------------------------------------------------------
module tsw_fault_src
    import tsw_pkg::*;
(
    input wire logic i_mclk,
    input wire logic [15:0] i_cond,
    input wire tsw_other_cause_t i_cause,
    output logic [15:0] o_alarm_raw,
    output tsw_other_cause_t o_other_cause
);
    timeunit 1ns;
    timeprecision 1ps;

    // Detector outputs change one edge after the condition
    always_ff @(posedge i_mclk) begin
        o_alarm_raw <= i_cond;
        o_other_cause <= i_cause;
    end
endmodule

// ===== tb/tsw_trip_status_tb.sv
// Self-checking bench for the trip status word logic.
// Assumes the fault detector model and a shortened 4-cycle tick.
module tsw_trip_status_tb;
    import tsw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICK = 4;
    localparam logic [15:0] EXT [8] = '{16'hf001, 16'hf002, 16'hf005, 16'hf006,
        16'hf200, 16'hf400, 16'hff05, 16'hff06};

    logic i_mclk = 1'b0;
    logic i_rst_b = 1'b0;
    logic start = 1'b0;
    logic down = 1'b0;
    logic [15:0] cond = 16'h0000;
    tsw_other_cause_t cause = TSW_OTH_AUTOTUNE_ERROR;
    tsw_bus_req_t bus = '0;
    logic [15:0] raw, word, first, latest, m;
    tsw_other_cause_t oc;
    logic [31:0] rdata;
    logic tripped;
    int mismatches = 0;
    int checks_done = 0;

    always #2.5 i_mclk = ~i_mclk;

    tsw_fault_src src (.i_mclk(i_mclk), .i_cond(cond), .i_cause(cause),
        .o_alarm_raw(raw), .o_other_cause(oc));

    tsw_trip_status #(.P_TICK_CYC(TICK)) uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_alarm_raw(raw), .i_other_cause(oc), .i_run_start_input(start),
        .i_down_key(down), .i_bus(bus), .o_rdata(rdata), .o_trip_status_word(word),
        .o_first_trip_capture(first), .o_latest_alarm_code(latest), .o_tripped(tripped));

    // ------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] txt(input logic [15:0] v);
        logic [31:0] t;
        for (int i = 0; i < 4; i++) begin
            t[8*i+:8] = (v[4*i+:4] < 4'ha) ? 8'h30 + {4'h0, v[4*i+:4]}
                                            : 8'h37 + {4'h0, v[4*i+:4]};
        end
        return t;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Register port and stimulus tasks
    // ------------------------------------------------------------
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        bus <= '0;
        #1;
        chk(what, exp, rdata);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk);
        bus <= '0;
    endtask

    task automatic drive(input logic [15:0] c);
        @(posedge i_mclk);
        cond <= c;
        settle(4);
    endtask

    task automatic pulse(input bit is_down);
        @(posedge i_mclk);
        if (is_down) down <= 1'b1;
        else start <= 1'b1;
        @(posedge i_mclk);
        down <= 1'b0;
        start <= 1'b0;
        settle(2);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        $display("[ERR] run time expected finish seen timeout");
        conclude();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h8c57));
        repeat (12) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        settle(1);
        rchk("latest reg", TSW_A_LATEST, 32'h0);
        rchk("word reg", TSW_A_WORD, 32'h0);
        rchk("first reg", TSW_A_FIRST, 32'h0);
        rchk("enable reg", TSW_A_ENABLE, 32'h0000ffff);
        rchk("unmapped", 8'h40, 32'h0);
        $display("test reset done");
        drive(16'h0020);
        chk("word", 16'h0020, word);
        chk("first", 16'h0020, first);
        chk("latest", 16'h0020, latest);
        chk("tripped", 1'b1, tripped);
        drive(16'h01a0);
        chk("word", 16'h01a0, word);
        chk("first", 16'h0020, first);
        chk("latest", 16'h0180, latest);
        drive(16'h01a8);
        chk("word early", 16'h01a0, word);
        settle(750 * TICK + 20);
        chk("word", 16'h01a8, word);
        rchk("word text", TSW_A_WORD_TEXT, txt(16'h01a8));
        rchk("first text", TSW_A_FIRST_TEXT, txt(16'h0020));
        rchk("latest text", TSW_A_LATEST_TEXT, txt(16'h0008));
        chk("latest", 16'h0008, latest);
        pulse(1'b1);
        chk("latest down", 16'h0000, latest);
        @(posedge i_mclk);
        start <= 1'b1;
        settle(2);
        chk("first at start", 16'h0000, first);
        chk("word at start", 16'h01a8, word);
        @(posedge i_mclk);
        start <= 1'b0;
        drive(16'h0000);
        pulse(1'b0);
        chk("word cleared", 16'h0000, word);
        chk("first cleared", 16'h0000, first);
        $display("test health set done");
        for (int k = 0; k < 8; k++) begin
            @(posedge i_mclk);
            cause <= tsw_other_cause_t'(k);
            drive(16'h4000);
            chk("latest ext", EXT[k], latest);
            chk("word other", 16'h4000, word);
            rchk("latest ext text", TSW_A_LATEST_TEXT, txt(EXT[k]));
            drive(16'h0000);
            pulse(1'b1);
            pulse(1'b0);
        end
        $display("test extended codes done");
        wr(TSW_A_ENABLE, 32'h0000ffef);
        rchk("enable rb", TSW_A_ENABLE, 32'h0000ffef);
        drive(16'h0030);
        chk("word masked", 16'h0020, word);
        wr(TSW_A_ENABLE, 32'h0000ffff);
        drive(16'h0000);
        pulse(1'b0);
        drive(16'h0001);
        settle(99 * TICK - 10);
        chk("overspeed early", 16'h0000, word);
        settle(TICK + 20);
        chk("overspeed", 16'h0001, word);
        drive(16'h0000);
        pulse(1'b0);
        $display("test mask and delay done");
        repeat (40) begin
            pulse(1'b1);
            m = 16'($urandom) & 16'hbff0;
            drive(m);
            chk("word rnd", m, word);
            chk("first rnd", m, first);
            chk("latest rnd", m, latest);
            drive(16'h0000);
            pulse(1'b0);
            chk("word rnd clr", 16'h0000, word);
        end
        $display("test random done");
        conclude();
    end
endmodule
